// *** asram_ctrl.sv ***
`timescale 1ns/1ps
module asram_ctrl
   import asram_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // User request.
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic [1:0] req_lanes,
   input wire logic retention_exit,
   // User answer.
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   // Memory pins.
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_select1_n,
   output logic mem_select2,
   output logic mem_write_n,
   output logic mem_output_enable_n,
   output logic upper_lane_select_n,
   output logic lower_lane_select_n,
   input wire logic [DATA_W-1:0] mem_data_in,
   output logic [DATA_W-1:0] mem_data_out,
   output logic mem_data_oe_n
);
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_READ = 8'h02,
      ST_RDONE = 8'h04,
      ST_WSET = 8'h08,
      ST_WPULSE = 8'h10,
      ST_WEND = 8'h20,
      ST_TURN = 8'h40,
      ST_RECOVER = 8'h80
   } asram_state_type;

   asram_state_type state_ff;
   logic [DATA_W-1:0] sync1_ff;
   logic [DATA_W-1:0] sync2_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [1:0] lanes_ff;
   logic rsp_ff;
   logic load;
   logic [CNT_W-1:0] count;
   logic done;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n);
   endfunction

   asram_timer u_timer (
      .clk(clk),
      .rstn(rstn),
      .load(load),
      .count(count),
      .done(done)
   );

   assign req_ready = (state_ff == ST_IDLE);

   // Read data crosses from the pins through two stages.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= mem_data_in;
         sync2_ff <= sync1_ff;
      end
   end

   always_comb begin
      load = 1'b0;
      count = '0;
      case (state_ff)
         ST_IDLE: begin
            if (req_valid && req_ready) begin
               load = 1'b1;
               count = req_write ? cyc(WRITE_CYCLES - WRITE_PULSE_CYCLES) : cyc(READ_CYCLES + 1);
            end else if (retention_exit) begin
               load = 1'b1;
               count = cyc(RECOVERY_CYCLES);
            end
         end
         ST_RDONE: begin
            load = 1'b1;
            count = cyc(RELEASE_CYCLES);
         end
         ST_WSET: begin
            load = done;
            count = cyc(WRITE_PULSE_CYCLES);
         end
         ST_WEND: begin
            load = 1'b1;
            count = cyc(RELEASE_CYCLES);
         end
         default: begin
            load = 1'b0;
            count = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (req_valid) begin
                  state_ff <= req_write ? ST_WSET : ST_READ;
               end else if (retention_exit) begin
                  state_ff <= ST_RECOVER;
               end
            end
            ST_READ: begin
               if (done) begin
                  state_ff <= ST_RDONE;
               end
            end
            ST_RDONE: state_ff <= ST_TURN;
            ST_WSET: begin
               if (done) begin
                  state_ff <= ST_WPULSE;
               end
            end
            ST_WPULSE: begin
               if (done) begin
                  state_ff <= ST_WEND;
               end
            end
            ST_WEND: state_ff <= ST_TURN;
            ST_TURN, ST_RECOVER: begin
               if (done) begin
                  state_ff <= ST_IDLE;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // Request capture; address and data stay fixed for the whole access.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_ff <= '0;
         wdata_ff <= '0;
         lanes_ff <= 2'h0;
      end else if (req_valid && req_ready) begin
         addr_ff <= req_addr;
         wdata_ff <= req_wdata;
         lanes_ff <= req_lanes;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_ff <= '0;
         rsp_ff <= 1'b0;
      end else begin
         rsp_ff <= (state_ff == ST_RDONE);
         if (state_ff == ST_RDONE) begin
            rdata_ff <= sync2_ff & {{8{lanes_ff[1]}}, {8{lanes_ff[0]}}};
         end
      end
   end
   assign rsp_valid = rsp_ff;
   assign rsp_rdata = rdata_ff;

   // Pin drive. Selects fall on the same edge that puts the new address on mem_addr.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mem_addr <= '0;
         mem_select1_n <= 1'b1;
         mem_select2 <= 1'b0;
         mem_write_n <= 1'b1;
         mem_output_enable_n <= 1'b1;
         upper_lane_select_n <= 1'b1;
         lower_lane_select_n <= 1'b1;
         mem_data_out <= '0;
         mem_data_oe_n <= 1'b1;
      end else begin
         mem_addr <= addr_ff;
         mem_select1_n <= !(state_ff inside {ST_READ, ST_RDONE, ST_WSET, ST_WPULSE});
         mem_select2 <= (state_ff inside {ST_READ, ST_RDONE, ST_WSET, ST_WPULSE});
         upper_lane_select_n <= !((state_ff inside {ST_READ, ST_RDONE, ST_WSET, ST_WPULSE}) && lanes_ff[1]);
         lower_lane_select_n <= !((state_ff inside {ST_READ, ST_RDONE, ST_WSET, ST_WPULSE}) && lanes_ff[0]);
         mem_output_enable_n <= !(state_ff inside {ST_READ, ST_RDONE});
         mem_write_n <= (state_ff != ST_WPULSE);
         mem_data_out <= wdata_ff;
         mem_data_oe_n <= !(state_ff inside {ST_WSET, ST_WPULSE, ST_WEND});
      end
   end
endmodule // asram_ctrl

// *** asram_pkg.sv ***
package asram_pkg;
   // Memory organisation.
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int CLK_PERIOD_PS = 5000;
   // Pin timing figures in ns.
   localparam int READ_CYCLE_MIN_NS = 45;
   localparam int WRITE_CYCLE_MIN_NS = 45;
   localparam int WRITE_PULSE_MIN_NS = 35;
   localparam int SELECT_TO_END_NS = 35;
   localparam int ADDRESS_SETUP_END_NS = 35;
   localparam int WRITE_DATA_SETUP_NS = 25;
   localparam int ADDRESS_ACCESS_TIME_NS = 45;
   localparam int OE_ACCESS_NS = 22;
   localparam int RELEASE_MAX_NS = 18;
   localparam int RECOVERY_MIN_NS = 45;
   // Least and greatest times round up to whole cycles.
   localparam int READ_CYCLES = (READ_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACCESS_CYCLES = (ADDRESS_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRITE_PULSE_CYCLES = (WRITE_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRITE_CYCLES = (WRITE_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RELEASE_CYCLES = (RELEASE_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RECOVERY_CYCLES = (RECOVERY_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 8;
   localparam logic [7:0] STATE_RESET = 8'h00;
endpackage

// *** asram_timer.sv ***
`timescale 1ns/1ps
module asram_timer
   import asram_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Control.
   input wire logic load,
   input wire logic [CNT_W-1:0] count,
   // Status.
   output logic done
);
   logic [CNT_W-1:0] cnt_ff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= count;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - CNT_W'(1);
      end
   end

   // The caller derives load from done in one state, so done must not look at load.
   assign done = (cnt_ff == '0);
endmodule // asram_timer

// *** asram_ctrl_checker.sv ***
`timescale 1ns/1ps
module asram_ctrl_checker
   import asram_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // User side.
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic retention_exit,
   // Memory pins.
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_select1_n,
   input wire logic mem_write_n,
   input wire logic mem_output_enable_n,
   input wire logic upper_lane_select_n,
   input wire logic lower_lane_select_n,
   input wire logic [DATA_W-1:0] mem_data_out,
   input wire logic mem_data_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence wr_hold; !mem_write_n ##1 !mem_write_n; endsequence
   sequence wr_end; $rose(mem_write_n); endsequence
   chk_read_cycle_len: assert property ($fell(mem_output_enable_n) |=> !mem_output_enable_n [*8])
      else $error("short read");
   chk_write_pulse_len: assert property ($fell(mem_write_n) |=> !mem_write_n [*6])
      else $error("short strobe");
   chk_select_early: assert property (wr_end |-> !$past(mem_select1_n, 7))
      else $error("late select");
   chk_write_addr_hold: assert property (wr_hold |-> $stable(mem_addr))
      else $error("address moved");
   chk_write_data_setup: assert property (wr_end |-> $past(mem_data_out, 5) == mem_data_out && !$past(mem_data_oe_n, 5))
      else $error("late data");
   chk_no_bus_fight: assert property (!mem_output_enable_n |-> mem_data_oe_n && mem_write_n)
      else $error("bus fight");
   chk_read_turnaround: assert property ($rose(mem_output_enable_n) |-> mem_data_oe_n [*4])
      else $error("drive too soon");
   chk_lane_quiet: assert property (mem_select1_n && $past(mem_select1_n) |-> $stable({upper_lane_select_n, lower_lane_select_n}))
      else $error("lane toggled");
   chk_recovery_wait: assert property (retention_exit && req_ready && !req_valid |=> mem_select1_n [*8])
      else $error("early access");
endmodule // asram_ctrl_checker
bind asram_ctrl asram_ctrl_checker u_chk (.*);

// *** asram_mem_model.sv ***
`timescale 1ns/1ps
module asram_mem_model
   import asram_pkg::*;
#(
   parameter int DELAY_NS = 18
)
(
   // Memory pins.
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic mem_select1_n,
   input wire logic mem_select2,
   input wire logic mem_write_n,
   input wire logic mem_output_enable_n,
   input wire logic upper_lane_select_n,
   input wire logic lower_lane_select_n,
   input wire logic [DATA_W-1:0] mem_data_out,
   input wire logic mem_data_oe_n,
   // Resolved bus.
   output logic [DATA_W-1:0] bus
);
   logic [DATA_W-1:0] mem_ff [2**ADDR_W];
   logic [DATA_W-1:0] rd;
   logic sel;
   logic drv;
   assign sel = !mem_select1_n && mem_select2 && !(upper_lane_select_n && lower_lane_select_n);
   assign #(DELAY_NS) drv = sel && mem_write_n && !mem_output_enable_n;
   assign #(DELAY_NS) rd = mem_ff[mem_addr];
   always @* begin
      if (sel && !mem_write_n && !mem_data_oe_n && !lower_lane_select_n) mem_ff[mem_addr][7:0] = mem_data_out[7:0];
      if (sel && !mem_write_n && !mem_data_oe_n && !upper_lane_select_n) mem_ff[mem_addr][15:8] = mem_data_out[15:8];
   end
   assign bus = !mem_data_oe_n ? mem_data_out : {(drv && !upper_lane_select_n) ? rd[15:8] : ~mem_data_out[15:8],
                                                 (drv && !lower_lane_select_n) ? rd[7:0] : ~mem_data_out[7:0]};
endmodule // asram_mem_model

// *** asram_ctrl_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("wrong value %0t %h %h", $time, g, e); end end
module asram_ctrl_test
   import asram_pkg::*;
;
   logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0, retention_exit = 1'b0;
   logic req_ready, rsp_valid, mem_select1_n, mem_select2, mem_write_n, mem_output_enable_n;
   logic upper_lane_select_n, lower_lane_select_n, mem_data_oe_n;
   logic [ADDR_W-1:0] req_addr = 18'h0, mem_addr;
   logic [DATA_W-1:0] req_wdata = 16'h0, rsp_rdata, mem_data_in, mem_data_out;
   logic [1:0] req_lanes = 2'h3;
   int mismatches = 0, num_checks = 0, cycles = 0;
   asram_ctrl u_dut (.*);
   asram_mem_model u_mem (.bus(mem_data_in), .*);
   initial forever #2.5 clk = ~clk;
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // The idle edge after the take keeps valid from being written twice in one step.
   task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
         input logic [1:0] l, output logic [DATA_W-1:0] q);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      req_lanes <= l;
      @(posedge clk);
      while (req_ready !== 1'b1) @(posedge clk);
      req_valid <= 1'b0;
      @(posedge clk);
      q = 16'h0;
      if (!w) begin
         while (rsp_valid !== 1'b1) @(posedge clk);
         q = rsp_rdata;
      end
   endtask
   task automatic test_words();
      logic [DATA_W-1:0] q;
      op(1'b1, 18'h0, 16'h1234, 2'h3, q);
      op(1'b1, 18'h3ffff, 16'habcd, 2'h3, q);
      op(1'b0, 18'h0, 16'h0, 2'h3, q);
      `CHK(q, 16'h1234)
      op(1'b0, 18'h3ffff, 16'h0, 2'h3, q);
      `CHK(q, 16'habcd)
      op(1'b0, 18'h0, 16'h0, 2'h2, q);
      `CHK(q, 16'h1200)
      $display("test words done");
   endtask
   task automatic test_lanes();
      logic [DATA_W-1:0] q;
      for (int l = 1; l < 3; l++) begin
         op(1'b1, 18'h5, 16'hffff, 2'h3, q);
         op(1'b1, 18'h5, 16'h0, l[1:0], q);
         op(1'b0, 18'h5, 16'h0, 2'h3, q);
         `CHK(q, (l == 1) ? 16'hff00 : 16'h00ff)
      end
      $display("test lanes done");
   endtask
   task automatic test_recovery();
      logic [DATA_W-1:0] q;
      int n;
      n = 0;
      retention_exit <= 1'b1;
      @(posedge clk);
      // The pulse only counts in idle, so it stands until the controller is ready.
      while (req_ready !== 1'b1) @(posedge clk);
      retention_exit <= 1'b0;
      fork
         op(1'b0, 18'h5, 16'h0, 2'h3, q);
         while (mem_select1_n === 1'b1) begin
            n++;
            @(posedge clk);
         end
      join
      `CHK(n >= RECOVERY_CYCLES, 1'b1)
      $display("test recovery done");
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         results();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      test_words();
      test_lanes();
      test_recovery();
      results();
   end
endmodule // asram_ctrl_test
